// ===== epms_top.sv
`timescale 1ns/100ps
`default_nettype none
// Function
// R1: Summary wear-out flag in the status word is set when any sector wore out.
// R2: Opcode E8h prepares the sector wear-out word in the response register.
// R3: Wear-out word holds sector flags in bits 31:24, sector 0 at bit 24.
// R4: Host polls status until ready is low before fetching the wear-out result.
// R5: A single byte write erases and programs its whole 32-bit word.
// R6: Endurance is tracked and reported per 128-byte page; the wear-out word reports it per sector.
// R7: Supply-read command measures the main supply into the response register.
// R8: Host polls status until ready is low before fetching the supply result.
// R9: Supply result is a 4-bit code in bits 7:4, low bits zero.
// R10: After power-up the device boots into standby.
// R11: Power-down disables references, internal supplies and tristates outputs.
// R12: Chip select low at start-up ramps supplies, ready after wake time.
// R13: Chip select falling edge wakes from power-down, armed 1 ms after start.
// R14: Wake input low at start-up holds power-down until it rises.
// R15: Host drives wake input low again before returning to power-down.
// R16: Opcode E2h enters power-down unless a program cycle is running.
// R17: Opcode E1h enters sleep unless a program cycle is running.
// R18: Sleep accepts only standby, status read and power-down opcodes.
// R19: Sleep powers down the array, keeps supplies and link, no auxiliary supply.
// R20: Program state starts only after chip select rises with complete data.
// R21: Opcode E0h in sleep returns to standby after the sleep wake time.
// R22: Opcode F9h shifts out the 32-bit response register.
// R23: Ready bit is high from prepare acceptance until the result is loaded.
// R24: Supply opcode is a parameter; response holds until the next prepare.
module epms_top
  import epms_pkg::*;
#(
  parameter int ARM_CYC = T_ARM_NS / CLK_NS,
  parameter int T_WAKE_NS = 1000,
  parameter int T_WAKE_PD_NS = 2000,
  parameter int T_WAKE_SLEEP_NS = 400,
  parameter logic [7:0] SUPPLY_OP = OP_SUPPLY_DEF,
  parameter int ADDR_W = 19
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic wake,
  output logic miso,
  output logic miso_oe_n,
  input wire logic [3:0] supply_code,
  input wire logic write_complete,
  input wire logic [ADDR_W-1:0] write_addr,
  input wire logic prog_done,
  input wire logic page_worn,
  input wire logic [ADDR_W-PAGE_SHIFT-1:0] worn_page,
  output logic prog_active,
  output logic [ADDR_W-WORD_SHIFT-1:0] prog_word,
  output logic [ADDR_W-PAGE_SHIFT-1:0] prog_page,
  output logic rdy_busy,
  output epms_pwr_t pwr
);

  localparam int PAGE_W = ADDR_W - PAGE_SHIFT;
  localparam int WAKE_CYC = (T_WAKE_NS + CLK_NS - 1) / CLK_NS;
  localparam int WAKE_PD_CYC = (T_WAKE_PD_NS + CLK_NS - 1) / CLK_NS;
  localparam int WAKE_SL_CYC = (T_WAKE_SLEEP_NS + CLK_NS - 1) / CLK_NS;

  if (ARM_CYC < 1 || ARM_CYC >= 2 ** CNT_W || WAKE_CYC < 1 || WAKE_PD_CYC < 1 ||
      WAKE_SL_CYC < 1 || WAKE_CYC >= 2 ** CNT_W || WAKE_PD_CYC >= 2 ** CNT_W ||
      WAKE_SL_CYC >= 2 ** CNT_W || PAGE_W < SECT_W) begin : g_bad_param
    $error("epms_top: timing or address parameter out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  epms_state_t st_q, st_d;
  logic cs_m_q, cs_s_q, cs_p_q;
  logic wk_m_q, wk_s_q, wk_p_q;
  logic tg_m_q, tg_s_q, tg_p_q;
  logic [1:0] boot_cnt_q;
  logic [CNT_W-1:0] arm_cnt_q;
  logic [CNT_W-1:0] wcnt_q, wcnt_d;
  logic [2:0] prep_cnt_q;
  logic prep_wear_q;
  logic [WORD_W-1:0] resp_q;
  logic prog_q;
  logic [SECT_N-1:0] worn_q;
  logic pd_q;
  logic [ADDR_W-WORD_SHIFT-1:0] prog_word_q;
  logic [PAGE_W-1:0] prog_page_q;
  epms_pwr_t pwr_q;
  epms_words_t pub_q;
  logic [7:0] link_op;
  logic link_tgl;
  logic link_miso_oe_n;

  ////////////////////////////////////////////////////////////////////////////
  epms_link u_link (
    .sclk(sclk),
    .cs_n(cs_n),
    .mosi(mosi),
    .reset(reset),
    .words(pub_q),
    .opcode(link_op),
    .cmd_tgl(link_tgl),
    .miso(miso),
    .miso_oe_n(link_miso_oe_n)
  );

  // Outputs stay in high impedance whatever the link does in power-down.
  assign miso_oe_n = link_miso_oe_n | pd_q; // R11

  ////////////////////////////////////////////////////////////////////////////
  wire cmd_go = tg_s_q ^ tg_p_q;
  wire is_pd = cmd_go && (link_op == OP_PDOWN);
  wire is_sl = cmd_go && (link_op == OP_SLEEP);
  wire is_sb = cmd_go && (link_op == OP_STANDBY);
  wire is_wear = link_op == OP_WEAR;
  wire is_sup = link_op == SUPPLY_OP; // R24
  wire prep_go = cmd_go && (st_q == ST_STANDBY) && (is_wear || is_sup); // R2 R7
  wire prep_busy = prep_cnt_q != 3'h0;
  wire cs_fall = cs_p_q && !cs_s_q;
  wire cs_rise = !cs_p_q && cs_s_q;
  wire wake_rise = wk_s_q && !wk_p_q;
  wire armed = arm_cnt_q == CNT_W'(ARM_CYC); // R13
  wire boot_done = boot_cnt_q == BOOT_CYC;
  wire waking = (st_q == ST_WAKE) || (st_q == ST_SWAKE) || (st_q == ST_BOOT);
  wire wear_out_summary_flag = |worn_q; // R1
  wire [1:0] pmi = (st_q == ST_SLEEP) ? PMI_SLEEP : PMI_STANDBY;
  wire busy = prep_busy || prog_q || waking; // R23
  wire [WORD_W-1:0] status_word = (WORD_W'(busy) << SR_RDY_BIT) |
    (WORD_W'(pmi) << PMI_LSB) | (WORD_W'(wear_out_summary_flag) << SUMMARY_BIT); // R1
  wire [WORD_W-1:0] wear_word = WORD_W'(worn_q) << SECT_FLAG_LSB; // R3
  wire [WORD_W-1:0] sup_word = WORD_W'(supply_code) << LEVEL_LSB; // R9
  wire prog_go = cs_rise && write_complete && (st_q == ST_STANDBY); // R20
  wire [SECT_W-1:0] worn_sect = worn_page[PAGE_W-1 -: SECT_W]; // R6

  ////////////////////////////////////////////////////////////////////////////
  // Pins are from outside the clock domain; the first stage is never read, edges compare stages two and three.
  always_ff @(posedge clk) begin
    if (reset) begin
      {cs_m_q, cs_s_q, cs_p_q} <= 3'h7;
      {wk_m_q, wk_s_q, wk_p_q} <= 3'h0;
      {tg_m_q, tg_s_q, tg_p_q} <= 3'h0;
    end else begin
      {cs_m_q, cs_s_q, cs_p_q} <= {cs_n, cs_m_q, cs_s_q};
      {wk_m_q, wk_s_q, wk_p_q} <= {wake, wk_m_q, wk_s_q};
      {tg_m_q, tg_s_q, tg_p_q} <= {link_tgl, tg_m_q, tg_s_q};
    end
  end

  always_comb begin
    st_d = st_q;
    wcnt_d = (wcnt_q != '0) ? wcnt_q - CNT_W'(1) : wcnt_q;
    unique case (st_q)
      ST_BOOT: begin
        if (boot_done) begin
          if (!wk_s_q) begin
            st_d = ST_PDOWN; // R14
          end else if (!cs_s_q) begin
            st_d = ST_WAKE; // R12
            wcnt_d = CNT_W'(WAKE_CYC);
          end else begin
            st_d = ST_STANDBY; // R10
          end
        end
      end
      ST_PDOWN: begin
        if (wake_rise) begin
          st_d = ST_WAKE; // R14
          wcnt_d = CNT_W'(WAKE_PD_CYC);
        end else if (cs_fall && armed) begin
          st_d = ST_WAKE; // R13
          wcnt_d = CNT_W'(WAKE_CYC);
        end
      end
      ST_WAKE, ST_SWAKE: begin
        if (wcnt_q == '0) begin
          st_d = ST_STANDBY;
        end
      end
      ST_STANDBY: begin
        if (is_pd && !prog_q) begin
          st_d = ST_PDOWN; // R16
        end else if (is_sl && !prog_q) begin
          st_d = ST_SLEEP; // R17
        end
      end
      ST_SLEEP: begin
        if (is_sb) begin
          st_d = ST_SWAKE; // R21
          wcnt_d = CNT_W'(WAKE_SL_CYC);
        end else if (is_pd) begin
          st_d = ST_PDOWN; // R18
        end
      end
      default: begin
        st_d = ST_BOOT;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_q <= ST_BOOT;
      wcnt_q <= '0;
      boot_cnt_q <= 2'h0;
      arm_cnt_q <= '0;
    end else begin
      st_q <= st_d;
      wcnt_q <= wcnt_d;
      boot_cnt_q <= boot_done ? boot_cnt_q : boot_cnt_q + 2'h1;
      arm_cnt_q <= armed ? arm_cnt_q : arm_cnt_q + CNT_W'(1); // R13
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // The result stays put until the next prepare, so late reads are safe.
  always_ff @(posedge clk) begin
    if (reset) begin
      prep_cnt_q <= 3'h0;
      prep_wear_q <= 1'b0;
      resp_q <= 32'h0000_0000;
    end else if (prep_go) begin
      prep_cnt_q <= PREP_CYC; // R23
      prep_wear_q <= is_wear;
    end else if (prep_busy) begin
      prep_cnt_q <= prep_cnt_q - 3'h1;
      if (prep_cnt_q == 3'h1) begin
        resp_q <= prep_wear_q ? wear_word : sup_word; // R2 R7 R24
      end
    end
  end

  // A done strobe in the start cycle loses to the new program start.
  always_ff @(posedge clk) begin
    if (reset) begin
      prog_q <= 1'b0;
      prog_word_q <= '0;
      prog_page_q <= '0;
    end else if (prog_go) begin
      prog_q <= 1'b1; // R20
      prog_word_q <= write_addr[ADDR_W-1:WORD_SHIFT]; // R5
      prog_page_q <= write_addr[ADDR_W-1:PAGE_SHIFT]; // R6
    end else if (prog_done) begin
      prog_q <= 1'b0;
    end
  end

  for (genvar i = 0; i < SECT_N; i++) begin : g_sect
    always_ff @(posedge clk) begin
      if (reset) begin
        worn_q[i] <= 1'b0;
      end else if (page_worn && (worn_sect == SECT_W'(i))) begin
        worn_q[i] <= 1'b1; // R6
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Words are only republished while no frame is seen; the link reads them
  // a whole opcode byte after the frame starts, long after they settle.
  always_ff @(posedge clk) begin
    if (reset) begin
      pub_q <= '0;
      pd_q <= 1'b0;
      pwr_q <= '0;
    end else begin
      if (cs_s_q) begin
        pub_q.status <= status_word;
        pub_q.resp <= resp_q; // R22
        pub_q.resp_ok <= st_q == ST_STANDBY; // R18
      end
      pd_q <= st_d == ST_PDOWN; // R11
      pwr_q.refs_en <= (st_d != ST_PDOWN); // R11
      pwr_q.supplies_en <= (st_d != ST_PDOWN); // R11 R19
      pwr_q.array_en <= (st_d == ST_STANDBY); // R19
      pwr_q.aux_avail <= (st_d == ST_STANDBY); // R19
    end
  end

  assign pwr = pwr_q;
  assign rdy_busy = busy;
  assign prog_active = prog_q;
  assign prog_word = prog_word_q;
  assign prog_page = prog_page_q;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  property p_boot;
    (st_q == ST_BOOT && boot_done && wk_s_q && cs_s_q) |=> st_q == ST_STANDBY;
  endproperty
  a_boot: assert property (p_boot) else $error("boot did not reach standby"); // R10

  property p_pd_outs;
    (st_q == ST_PDOWN) |-> (pwr_q == '0 && miso_oe_n);
  endproperty
  a_pd_outs: assert property (p_pd_outs) else $error("power-down outputs live"); // R11

  property p_arm;
    (st_q == ST_PDOWN && cs_fall && !armed && !wake_rise) |=> st_q == ST_PDOWN;
  endproperty
  a_arm: assert property (p_arm) else $error("wake before arming"); // R13

  property p_pd_cmd;
    (st_q == ST_STANDBY && is_pd && !prog_q) |=> ##1 (st_q == ST_PDOWN && pd_q);
  endproperty
  a_pd_cmd: assert property (p_pd_cmd) else $error("power-down not entered"); // R16

  property p_prog_block;
    (st_q == ST_STANDBY && (is_pd || is_sl) && prog_q) |=> st_q == ST_STANDBY;
  endproperty
  a_prog_block: assert property (p_prog_block) else $error("mode change in program"); // R17

  property p_sleep_filter;
    (st_q == ST_SLEEP && !is_sb && !is_pd) |=> st_q == ST_SLEEP;
  endproperty
  a_sleep_filter: assert property (p_sleep_filter) else $error("sleep left wrongly"); // R18

  property p_swake;
    (st_q == ST_SLEEP && is_sb) |=> (st_q == ST_SWAKE)[*2] ##[1:1000] st_q == ST_STANDBY;
  endproperty
  a_swake: assert property (p_swake) else $error("sleep wake failed"); // R21

  property p_prep;
    prep_go |=> busy[*4] ##1 (resp_q == (prep_wear_q ? wear_word : sup_word));
  endproperty
  a_prep: assert property (p_prep) else $error("prepare timing or result wrong"); // R23

  property p_resp_hold;
    (!prep_busy && !prep_go) |=> $stable(resp_q);
  endproperty
  a_resp_hold: assert property (p_resp_hold) else $error("response changed"); // R24

  property p_prog;
    prog_go |=> (prog_q && prog_word == $past(write_addr[ADDR_W-1:WORD_SHIFT]));
  endproperty
  a_prog: assert property (p_prog) else $error("program start wrong"); // R20

endmodule : epms_top
`default_nettype wire

// ===== epms_pkg.sv
package epms_pkg;

  localparam int CLK_NS = 8;
  localparam int T_ARM_NS = 1000000;
  localparam int WORD_W = 32;
  localparam int CNT_W = 17;

  localparam logic [7:0] OP_STANDBY = 8'hE0;
  localparam logic [7:0] OP_SLEEP = 8'hE1;
  localparam logic [7:0] OP_PDOWN = 8'hE2;
  localparam logic [7:0] OP_WEAR = 8'hE8;
  localparam logic [7:0] OP_RESP = 8'hF9;
  localparam logic [7:0] OP_STATUS = 8'h05;
  localparam logic [7:0] OP_SUPPLY_DEF = 8'hEA;

  localparam int SR_RDY_BIT = 24;
  localparam int PMI_LSB = 14;
  localparam int SUMMARY_BIT = 7;
  localparam int SECT_FLAG_LSB = 24;
  localparam int LEVEL_LSB = 4;
  localparam int SECT_N = 8;
  localparam int SECT_W = 3;
  localparam int WORD_SHIFT = 2;
  localparam int PAGE_SHIFT = 7;

  localparam logic [1:0] PMI_STANDBY = 2'h0;
  localparam logic [1:0] PMI_SLEEP = 2'h1;

  localparam logic [2:0] PREP_CYC = 3'h4;
  localparam logic [1:0] BOOT_CYC = 2'h3;
  localparam int OPC_BITS = 8;
  localparam int FRAME_BITS = 40;

  typedef enum logic [2:0] {
    ST_BOOT = 3'h0,
    ST_WAKE = 3'h1,
    ST_STANDBY = 3'h3,
    ST_SLEEP = 3'h2,
    ST_SWAKE = 3'h6,
    ST_PDOWN = 3'h4
  } epms_state_t;

  typedef struct packed {
    logic refs_en;
    logic supplies_en;
    logic array_en;
    logic aux_avail;
  } epms_pwr_t;

  typedef struct packed {
    logic [WORD_W-1:0] status;
    logic [WORD_W-1:0] resp;
    logic resp_ok;
  } epms_words_t;

endpackage : epms_pkg

// ===== epms_link.sv
`timescale 1ns/100ps
`default_nettype none
module epms_link
  import epms_pkg::*;
(
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic reset,
  input wire epms_words_t words,
  output logic [7:0] opcode,
  output logic cmd_tgl,
  output logic miso,
  output logic miso_oe_n
);

  logic [5:0] bit_cnt_q;
  logic [6:0] rx_q;
  logic [7:0] opcode_q;
  logic tgl_q;
  logic [WORD_W-1:0] tx_q;
  logic drv_q;

  ////////////////////////////////////////////////////////////////////////////
  wire opc_edge = (bit_cnt_q == 6'(OPC_BITS - 1));
  wire load_now = (bit_cnt_q == 6'(OPC_BITS)) && !drv_q;
  wire is_stat = (opcode_q == OP_STATUS);
  wire is_resp = (opcode_q == OP_RESP) && words.resp_ok;
  wire [WORD_W-1:0] tx_sel = is_stat ? words.status : words.resp;

  // The sclk only runs inside frames, so chip select clears the frame state.
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      bit_cnt_q <= 6'h00;
    end else if (bit_cnt_q != 6'(FRAME_BITS)) begin
      bit_cnt_q <= bit_cnt_q + 6'h01;
    end
  end

  always_ff @(posedge sclk) begin
    rx_q <= {rx_q[5:0], mosi};
  end

  // Opcode and toggle persist across frames; the core samples them later.
  always_ff @(posedge sclk or posedge reset) begin
    if (reset) begin
      opcode_q <= 8'h00;
      tgl_q <= 1'b0;
    end else if (!cs_n && opc_edge) begin
      opcode_q <= {rx_q, mosi};
      tgl_q <= ~tgl_q;
    end
  end

  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      tx_q <= 32'h0000_0000;
      drv_q <= 1'b0;
    end else if (load_now && (is_stat || is_resp)) begin
      tx_q <= tx_sel;
      drv_q <= 1'b1;
    end else if (drv_q) begin
      tx_q <= {tx_q[WORD_W-2:0], 1'b0};
    end
  end

  assign opcode = opcode_q;
  assign cmd_tgl = tgl_q;
  assign miso = tx_q[WORD_W-1];
  assign miso_oe_n = ~drv_q;

endmodule : epms_link
`default_nettype wire

// ===== epms_host.sv
`timescale 1ns/100ps
`default_nettype none
module epms_host (
  output logic sclk,
  output logic cs_n,
  output logic mosi,
  input wire logic miso,
  input wire logic miso_oe_n
);
  localparam realtime HALF = 62.5;

  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end

  // The data line toggles between frames so a stale level never reads as a bit.
  always #(HALF) if (cs_n) mosi = ~mosi;

  ////////////////////////////////////////////////////////////////////////////////
  // Mode 0 frame: opcode first, then 32 bits read; the clock stands still outside.
  task automatic xfer(input logic [7:0] op, output logic [31:0] rd, output logic drv);
    rd = '0;
    drv = 1'b1;
    #(HALF) cs_n = 1'b0;
    for (int i = 0; i < 40; i++) begin
      mosi = (i < 8) ? op[7-i] : i[0];
      #(HALF) sclk = 1'b1;
      if (i >= 8) begin
        // A released line reads as the inverse, so an undriven answer never passes.
        rd = {rd[30:0], miso_oe_n ? ~miso : miso};
        drv = drv & ~miso_oe_n;
      end
      #(HALF) sclk = 1'b0;
    end
    #(HALF) cs_n = 1'b1;
    #(4*HALF);
  endtask : xfer

  task automatic set_cs(input logic v);
    cs_n = v;
  endtask : set_cs
endmodule : epms_host
`default_nettype wire

// ===== test_eeprom_power_mode_and_status_cmds.sv
`timescale 1ns/100ps
`default_nettype none
module test_eeprom_power_mode_and_status_cmds;
  import epms_pkg::*;
  localparam int AW = 19;
  logic clk, reset, sclk, cs_n, mosi, wake, miso, miso_oe_n;
  logic write_complete, prog_done, page_worn, prog_active, rdy_busy, d;
  logic [3:0] supply_code;
  logic [AW-1:0] write_addr;
  logic [AW-PAGE_SHIFT-1:0] worn_page;
  logic [AW-PAGE_SHIFT-1:0] prog_page;
  logic [AW-WORD_SHIFT-1:0] prog_word;
  logic [31:0] w;
  epms_pwr_t pwr;
  int err_total, comparisons;

  epms_top #(.ARM_CYC(50), .ADDR_W(AW)) DUT (
    .clk(clk), .reset(reset), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .wake(wake),
    .miso(miso), .miso_oe_n(miso_oe_n), .supply_code(supply_code),
    .write_complete(write_complete), .write_addr(write_addr), .prog_done(prog_done),
    .page_worn(page_worn), .worn_page(worn_page), .prog_active(prog_active),
    .prog_word(prog_word), .prog_page(prog_page), .rdy_busy(rdy_busy), .pwr(pwr)
  );

  epms_host HOST (
    .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso), .miso_oe_n(miso_oe_n)
  );

  initial clk = 1'b0;
  always #(CLK_NS/2) clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  task automatic cmd(input logic [7:0] op);
    HOST.xfer(op, w, d);
    cyc(8);
  endtask : cmd

  // Bounded poll of the ready bit; a stuck busy ends as a mismatch, not a hang.
  task automatic poll();
    int k;
    k = 0;
    do begin
      HOST.xfer(OP_STATUS, w, d);
      k++;
    end while (w[24] !== 1'b0 && k < 20);
    check("ready", {31'h0, w[24]}, 32'h0);
    cyc(2);
  endtask : poll

  task automatic do_reset();
    reset = 1'b1;
    cyc(8);
    reset = 1'b0;
    cyc(10);
  endtask : do_reset

  task automatic mark_worn(input logic [2:0] sect);
    worn_page = {sect, 9'h1F};
    page_worn = 1'b1;
    cyc(1);
    page_worn = 1'b0;
    cyc(1);
  endtask : mark_worn

  task automatic close_out();
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : close_out

  initial begin
    #600000;
    err_total++;
    close_out();
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    err_total = 0;
    comparisons = 0;
    reset = 1'b1;
    wake = 1'b1;
    supply_code = 4'hA;
    write_complete = 1'b0;
    write_addr = '0;
    prog_done = 1'b0;
    page_worn = 1'b0;
    worn_page = '0;
    do_reset();
    check("pwr", {29'h0, pwr[3:1]}, 32'h7);
    cmd(OP_STATUS);
    check("status", w, 32'h0);
    $display("test boot done");
    cmd(OP_SUPPLY_DEF);
    poll();
    HOST.xfer(OP_RESP, w, d);
    check("supply", w, 32'h000000A0);
    check("resp_oe", {31'h0, d}, 32'h1);
    $display("test supply done");
    mark_worn(3'h5);
    mark_worn(3'h0);
    cmd(OP_STATUS);
    check("summary", w, 32'h00000080);
    cmd(OP_WEAR);
    poll();
    supply_code = 4'h3;
    HOST.xfer(OP_RESP, w, d);
    check("wear", w, 32'h21000000);
    HOST.xfer(OP_RESP, w, d);
    check("resp_hold", w, 32'h21000000);
    $display("test wear done");
    write_addr = 19'h5A5A7;
    write_complete = 1'b1;
    check("prog_idle", {31'h0, prog_active}, 32'h0);
    cmd(8'h02);
    write_complete = 1'b0;
    check("prog", {31'h0, prog_active}, 32'h1);
    check("word", {15'h0, prog_word}, 32'h16969);
    check("page", {20'h0, prog_page}, 32'hB4B);
    cmd(OP_SLEEP);
    cmd(OP_PDOWN);
    cmd(OP_STATUS);
    check("busy_mode", {16'h0, w[15:0]}, 32'h0080);
    check("busy_pwr", {29'h0, pwr[3:1]}, 32'h7);
    prog_done = 1'b1;
    cyc(1);
    prog_done = 1'b0;
    cyc(2);
    check("prog_end", {31'h0, prog_active}, 32'h0);
    $display("test program done");
    cmd(OP_SLEEP);
    check("sleep_pwr", {28'h0, pwr}, 32'hC);
    cmd(OP_STATUS);
    check("sleep_mode", {16'h0, w[15:0]}, 32'h4080);
    HOST.xfer(OP_RESP, w, d);
    check("sleep_resp", {31'h0, d}, 32'h0);
    cmd(OP_SUPPLY_DEF);
    cmd(OP_STANDBY);
    poll();
    check("standby_cmd_mode", {16'h0, w[15:0]}, 32'h0080);
    HOST.xfer(OP_RESP, w, d);
    check("sleep_prep", w, 32'h21000000);
    $display("test sleep done");
    cmd(OP_PDOWN);
    check("pd_pwr", {28'h0, pwr}, 32'h0);
    check("pd_oe", {31'h0, miso_oe_n}, 32'h1);
    HOST.set_cs(1'b0);
    cyc(3);
    HOST.set_cs(1'b1);
    cyc(200);
    poll();
    check("cs_wake", {29'h0, pwr[3:1]}, 32'h7);
    $display("test cs wake done");
    wake = 1'b0;
    cmd(OP_PDOWN);
    do_reset();
    HOST.set_cs(1'b0);
    cyc(3);
    HOST.set_cs(1'b1);
    cyc(20);
    check("wk_pd", {28'h0, pwr}, 32'h0);
    check("arm_hold", {31'h0, rdy_busy}, 32'h0);
    wake = 1'b1;
    cyc(300);
    poll();
    check("wk_pwr", {29'h0, pwr[3:1]}, 32'h7);
    $display("test wake pin done");
    HOST.set_cs(1'b0);
    do_reset();
    check("cs_boot", {31'h0, rdy_busy}, 32'h1);
    cyc(150);
    check("cs_ready", {31'h0, rdy_busy}, 32'h0);
    HOST.set_cs(1'b1);
    $display("test cs boot done");
    close_out();
  end
endmodule : test_eeprom_power_mode_and_status_cmds
`default_nettype wire
